// [rtl/fle_buf2.sv]
`timescale 1ns/100ps
`default_nettype none
// Two-entry buffer: a stall on the drain side loses no word
module fle_buf2 (
  input wire logic mclk,
  input wire logic reset_n,
  input wire fle_pkg::fle_word_s in_word,
  input wire logic in_valid,
  output logic in_ready,
  output fle_pkg::fle_word_s out_word,
  output logic out_valid,
  input wire logic out_ready
);
  import fle_pkg::*;
  fle_word_s mem_q [2]; // Flip-flop storage
  logic wp_q; // Write index
  logic rp_q; // Read index
  logic [1:0] cnt_q; // Fill level
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_word = mem_q[rp_q];
  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wp_q] <= in_word;
    end
  end
  // Pointers and level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// [rtl/fle_consts.svh]
`ifndef FLE_CONSTS_SVH
`define FLE_CONSTS_SVH
// ----------------------------------------
// Address map
// ----------------------------------------
`define FLE_OVL_RAM_BASE 24'hFF_DC00
`define FLE_BLK_SHIFT 12
`define FLE_BLK_LIMIT 24'h00_8000
`define FLE_PCP_BASE 24'hFF_EC00
`define FLE_PCP_LAST 24'hFF_FBFF
`define FLE_PCP_SIZE 16'h1000
// ----------------------------------------
// Mode pin patterns (mode_pin2..0)
// ----------------------------------------
`define FLE_MD_BOOT_EXP 3'h2
`define FLE_MD_BOOT_SC 3'h3
`define FLE_MD_UPM_EXP 3'h6
`define FLE_MD_UPM_SC 3'h7
// ----------------------------------------
// Serial timing: 100 MHz clock, 16x oversampled bit
// ----------------------------------------
`define FLE_BAUD_DIV 16'h0036
`define FLE_BAUD_DIV_INIT 16'h0000
`define FLE_SAMPLES 4'hF
`define FLE_HALF 4'h7
`define FLE_DATA_BITS 3'h7
`endif

// [rtl/fle_ctrl.sv]
// Behaviour
// - Select low: no overlay, no protection
// - Select high: overlay on, all blocks protected
// - Area bits pick 4-kbyte block overlaid
// - Program/erase/verify only in on-board modes
// - Boot runs loader on async serial port
// - Store bytes in RAM, then branch
`timescale 1ns/100ps
`default_nettype none
`include "fle_consts.svh"
module fle_ctrl (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic emulation_select,
  input wire logic area_select_bit2,
  input wire logic area_select_bit1,
  input wire logic area_select_bit0,
  input wire logic flash_write_enable_pin,
  input wire logic mode_pin2,
  input wire logic mode_pin1,
  input wire logic mode_pin0,
  input wire logic [23:0] cpu_addr,
  input wire logic [15:0] pcp_length,
  input wire logic serial_port_rxd,
  input wire logic ram_wr_ready,
  output logic [23:0] mapped_addr_q,
  output logic overlay_hit_q,
  output logic flash_protect_q,
  output logic prog_allowed_q,
  output logic boot_mode_q,
  output logic user_prog_mode_q,
  output logic ram_wr_valid_q,
  output fle_pkg::fle_word_s ram_wr_q,
  output logic branch_q,
  output logic [23:0] branch_addr_q,
  output logic rx_overrun_q
);
  import fle_pkg::*;

  // ----------------------------------------
  // Mode capture
  // ----------------------------------------
  logic [2:0] mode_pins;
  logic strap_done_q; // Straps caught once after reset release
  assign mode_pins = {mode_pin2, mode_pin1, mode_pin0};

  // Pins are latched by a clocked process after release, never by the reset itself
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done_q <= 1'b0;
      boot_mode_q <= 1'b0;
      user_prog_mode_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      boot_mode_q <= flash_write_enable_pin &&
        (mode_pins == `FLE_MD_BOOT_EXP || mode_pins == `FLE_MD_BOOT_SC);
      user_prog_mode_q <=
        (mode_pins == `FLE_MD_UPM_EXP || mode_pins == `FLE_MD_UPM_SC);
    end
  end

  // Programming allowed only in on-board modes with write enable held
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prog_allowed_q <= 1'b0;
    end else begin
      prog_allowed_q <= (boot_mode_q || user_prog_mode_q) && flash_write_enable_pin
        && !emulation_select;
    end
  end

  // ----------------------------------------
  // Emulation overlay
  // ----------------------------------------
  logic [2:0] area_sel;
  assign area_sel = {area_select_bit2, area_select_bit1, area_select_bit0};

  // Block number of a flash address, valid below the block limit
  function automatic logic [2:0] blk_of(input logic [23:0] a);
    blk_of = a[`FLE_BLK_SHIFT+2:`FLE_BLK_SHIFT];
  endfunction

  // Address remap is registered; one cycle of latency is traded for a flop output
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mapped_addr_q <= 24'h00_0000;
      overlay_hit_q <= 1'b0;
      flash_protect_q <= 1'b0;
    end else begin
      flash_protect_q <= emulation_select;
      if (emulation_select && cpu_addr < `FLE_BLK_LIMIT
          && blk_of(cpu_addr) == area_sel) begin
        overlay_hit_q <= 1'b1;
        mapped_addr_q <= `FLE_OVL_RAM_BASE + {12'h000, cpu_addr[`FLE_BLK_SHIFT-1:0]};
      end else begin
        // Area bits are ignored when emulation is off
        overlay_hit_q <= 1'b0;
        mapped_addr_q <= cpu_addr;
      end
    end
  end

  // ----------------------------------------
  // Serial receiver, 8N1, 16x oversampling
  // ----------------------------------------
  fle_rx_e rx_st_q;
  logic [15:0] div_q; // Oversample divider
  logic tick; // One-cycle sample enable
  logic [3:0] sub_q; // Sample count within a bit
  logic [2:0] bit_q; // Data bit index
  logic [7:0] sh_q; // Shift register
  logic rx_done_q; // Byte complete pulse
  logic [7:0] rx_byte_q;
  fle_boot_e boot_st_q;
  assign tick = (div_q == `FLE_BAUD_DIV);

  // Sample-rate divider
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= `FLE_BAUD_DIV_INIT;
    end else begin
      div_q <= tick ? `FLE_BAUD_DIV_INIT : div_q + 16'h0001;
    end
  end

  // Asynchronous receive state machine, active only while loading
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_q <= FLE_RX_IDLE;
      sub_q <= 4'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rx_done_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else begin
      rx_done_q <= 1'b0;
      if (tick) begin
        case (rx_st_q)
          FLE_RX_IDLE: begin
            sub_q <= 4'h0;
            // Only the loader listens on the port
            if (boot_st_q == FLE_LOAD && !serial_port_rxd) begin
              rx_st_q <= FLE_RX_START;
            end
          end
          FLE_RX_START: begin
            sub_q <= sub_q + 4'h1;
            if (sub_q == `FLE_HALF) begin
              // A glitch shorter than half a bit is not a start bit
              rx_st_q <= serial_port_rxd ? FLE_RX_IDLE : FLE_RX_DATA;
              sub_q <= 4'h0;
              bit_q <= 3'h0;
            end
          end
          FLE_RX_DATA: begin
            sub_q <= sub_q + 4'h1;
            if (sub_q == `FLE_SAMPLES) begin
              sh_q <= {serial_port_rxd, sh_q[7:1]}; // LSB first
              bit_q <= bit_q + 3'h1;
              if (bit_q == `FLE_DATA_BITS) begin
                rx_st_q <= FLE_RX_STOP;
              end
            end
          end
          FLE_RX_STOP: begin
            sub_q <= sub_q + 4'h1;
            if (sub_q == `FLE_SAMPLES) begin
              rx_st_q <= FLE_RX_IDLE;
              // Framing error drops the byte
              if (serial_port_rxd) begin
                rx_done_q <= 1'b1;
                rx_byte_q <= sh_q;
              end
            end
          end
          default: rx_st_q <= FLE_RX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Loader: bytes into program area, then branch
  // ----------------------------------------
  logic [15:0] count_q; // Bytes stored so far
  logic in_ready;
  fle_word_s in_word;
  fle_word_s out_word;
  logic out_valid;
  logic load_full; // Expected length reached or program area full
  assign in_word = '{addr: `FLE_PCP_BASE + {8'h00, count_q}, data: rx_byte_q};
  // Stray bytes past the length or the area end are never stored, so they can
  // neither write outside the program area nor hold off the branch
  assign load_full = (count_q == pcp_length) || (count_q == `FLE_PCP_SIZE);

  // Boot sequence
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      boot_st_q <= FLE_IDLE;
      count_q <= 16'h0000;
      branch_q <= 1'b0;
      branch_addr_q <= 24'h00_0000;
      rx_overrun_q <= 1'b0;
    end else begin
      branch_q <= 1'b0;
      case (boot_st_q)
        FLE_IDLE: begin
          if (strap_done_q && boot_mode_q && pcp_length != 16'h0000) begin
            boot_st_q <= FLE_LOAD;
          end
        end
        FLE_LOAD: begin
          if (rx_done_q && !load_full) begin
            if (in_ready) begin
              count_q <= count_q + 16'h0001;
            end else begin
              // Sticky: a byte arrived with the buffer full
              rx_overrun_q <= 1'b1;
            end
          end
          // Branch once the last byte has been written out
          if (load_full && !out_valid && !ram_wr_valid_q) begin
            boot_st_q <= FLE_RUN;
            branch_q <= 1'b1;
            branch_addr_q <= `FLE_PCP_BASE;
          end
        end
        FLE_RUN: boot_st_q <= FLE_RUN;
        default: boot_st_q <= FLE_IDLE;
      endcase
    end
  end

  fle_buf2 fle_buf2_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_word(in_word),
    .in_valid(rx_done_q && boot_st_q == FLE_LOAD && !load_full),
    .in_ready(in_ready),
    .out_word(out_word),
    .out_valid(out_valid),
    .out_ready(!ram_wr_valid_q || ram_wr_ready)
  );

  // RAM write port register, held until the RAM takes it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ram_wr_valid_q <= 1'b0;
      ram_wr_q <= '0;
    end else if (!ram_wr_valid_q || ram_wr_ready) begin
      ram_wr_valid_q <= out_valid;
      if (out_valid) begin
        ram_wr_q <= out_word;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/fle_pkg.sv]
package fle_pkg;
  // Boot mode step
  typedef enum logic [1:0] {FLE_IDLE, FLE_LOAD, FLE_RUN} fle_boot_e;
  // Serial receiver step
  typedef enum logic [1:0] {FLE_RX_IDLE, FLE_RX_START, FLE_RX_DATA, FLE_RX_STOP} fle_rx_e;
  // One received byte with its RAM address
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } fle_word_s;
endpackage

// [verif/fle_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port watcher for the flash control block
// ----------------------------------------
module fle_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic emulation_select,
  input wire logic area_select_bit2,
  input wire logic area_select_bit1,
  input wire logic area_select_bit0,
  input wire logic flash_write_enable_pin,
  input wire logic [23:0] cpu_addr,
  input wire logic ram_wr_ready,
  input wire logic [23:0] mapped_addr_q,
  input wire logic overlay_hit_q,
  input wire logic flash_protect_q,
  input wire logic prog_allowed_q,
  input wire logic boot_mode_q,
  input wire logic user_prog_mode_q,
  input wire logic ram_wr_valid_q,
  input wire fle_pkg::fle_word_s ram_wr_q,
  input wire logic branch_q,
  input wire logic [23:0] branch_addr_q
);
  import fle_pkg::*;
  // Block number picked by the three area bits
  logic [2:0] area;
  logic [11:0] ofs; // Offset inside a 4-kbyte block
  assign area = {area_select_bit2, area_select_bit1, area_select_bit0};
  assign ofs = cpu_addr[11:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_PROT_ON: assert property (emulation_select |=> flash_protect_q)
    else $error("protect did not follow select high");
  AST_PROT_OFF: assert property (!emulation_select |=> !flash_protect_q && !overlay_hit_q)
    else $error("overlay or protect active with select low");
  // Offset inside the 4-kbyte window must survive the remap
  // The window base is not aligned to 4 kbytes, so the offset is added, not merged
  AST_HIT: assert property (
    emulation_select && cpu_addr[23:15] == 9'h000 && cpu_addr[14:12] == area
    |=> overlay_hit_q && mapped_addr_q == 24'hFF_DC00 + {12'h000, $past(ofs)})
    else $error("selected block not redirected to overlay RAM");
  AST_MISS: assert property (emulation_select && cpu_addr[14:12] != area |=> !overlay_hit_q)
    else $error("unselected block redirected");
  AST_PROG: assert property (prog_allowed_q |-> (boot_mode_q || user_prog_mode_q)
    && $past(flash_write_enable_pin) && !$past(emulation_select))
    else $error("programming allowed outside on-board modes");
  AST_HOLD: assert property (ram_wr_valid_q && !ram_wr_ready
    |=> ram_wr_valid_q && $stable(ram_wr_q))
    else $error("RAM write request dropped before ready");
  AST_AREA: assert property (ram_wr_valid_q |-> boot_mode_q && ram_wr_q.addr >= 24'hFF_EC00
    && ram_wr_q.addr <= 24'hFF_FBFF)
    else $error("loader write outside program area");
  AST_BRANCH: assert property (branch_q |=> !branch_q && branch_addr_q == 24'hFF_EC00)
    else $error("branch not a pulse to the area start");
  AST_LATCH: assert property (boot_mode_q || user_prog_mode_q
    |=> $stable({boot_mode_q, user_prog_mode_q}))
    else $error("latched mode changed without reset");
endmodule
`default_nettype wire

// [verif/fle_ctrl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
  end \
end
// ----------------------------------------
// Bench top
// ----------------------------------------
module fle_ctrl_tb;
  import fle_pkg::*;
  logic mclk = 1'h0, reset_n = 1'h0, emulation_select = 1'h0, flash_write_enable_pin = 1'h0;
  logic area_select_bit2 = 1'h0, area_select_bit1 = 1'h0, area_select_bit0 = 1'h0;
  logic mode_pin2 = 1'h0, mode_pin1 = 1'h0, mode_pin0 = 1'h0, ram_wr_ready = 1'h0;
  logic [23:0] cpu_addr = 24'h00_0000, mapped_addr_q, branch_addr_q;
  logic [15:0] pcp_length = 16'h0003; // Three bytes keep the serial run short
  logic serial_port_rxd, overlay_hit_q, flash_protect_q, prog_allowed_q, boot_mode_q;
  logic user_prog_mode_q, ram_wr_valid_q, branch_q, rx_overrun_q;
  fle_word_s ram_wr_q;
  fle_word_s got[$]; // Every write the RAM side accepted
  int fails = 0, cmp_count = 0;
  int branch_cnt = 0; // Branch pulses seen since time zero
  always #5 mclk = ~mclk;
  fle_ctrl fle_ctrl_inst (.mclk(mclk), .reset_n(reset_n), .emulation_select(emulation_select),
    .area_select_bit2(area_select_bit2), .area_select_bit1(area_select_bit1),
    .area_select_bit0(area_select_bit0), .flash_write_enable_pin(flash_write_enable_pin),
    .mode_pin2(mode_pin2), .mode_pin1(mode_pin1), .mode_pin0(mode_pin0), .cpu_addr(cpu_addr),
    .pcp_length(pcp_length), .serial_port_rxd(serial_port_rxd), .ram_wr_ready(ram_wr_ready),
    .mapped_addr_q(mapped_addr_q), .overlay_hit_q(overlay_hit_q),
    .flash_protect_q(flash_protect_q), .prog_allowed_q(prog_allowed_q),
    .boot_mode_q(boot_mode_q), .user_prog_mode_q(user_prog_mode_q),
    .ram_wr_valid_q(ram_wr_valid_q), .ram_wr_q(ram_wr_q), .branch_q(branch_q),
    .branch_addr_q(branch_addr_q), .rx_overrun_q(rx_overrun_q));
  fle_host fle_host_inst (.mclk(mclk), .rxd(serial_port_rxd));
  // RAM side: record each accepted write
  always @(posedge mclk) if (ram_wr_valid_q && ram_wr_ready) got.push_back(ram_wr_q);
  // The branch is a one-cycle pulse; count it so a late look cannot miss it
  always @(posedge mclk) if (branch_q === 1'h1) branch_cnt++;
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Reset with straps held through it; checks land after latch and two more edges
  task automatic strap(input logic [2:0] md, input logic fw);
    @(posedge mclk);
    reset_n <= 1'h0;
    {mode_pin2, mode_pin1, mode_pin0} <= md;
    flash_write_enable_pin <= fw;
    repeat (3) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  // One address through the remap; result read one edge later
  task automatic remap(input logic es, input logic [2:0] a, input logic [23:0] ad);
    @(posedge mclk);
    emulation_select <= es;
    {area_select_bit2, area_select_bit1, area_select_bit0} <= a;
    cpu_addr <= ad;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  // Watchdog well past the serial transfer length
  initial begin
    #800000;
    fails++;
    stop_test();
  end
  initial begin
    logic [2:0] md [7] = '{3'h2, 3'h3, 3'h6, 3'h7, 3'h0, 3'h6, 3'h2};
    logic fw [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
    logic [7:0] dat [3] = '{8'hA5, 8'h3C, 8'h81};
    logic bm, um;
    for (int k = 0; k < 7; k++) begin
      strap(md[k], fw[k]);
      bm = md[k][2:1] == 2'h1 && fw[k];
      um = md[k][2:1] == 2'h3;
      `CHK(boot_mode_q, bm);
      `CHK(user_prog_mode_q, um);
      `CHK(prog_allowed_q, (bm | um) & fw[k]);
    end
    strap(3'h2, 1'h1);
    for (int b = 0; b < 8; b++) begin
      remap(1'h1, b[2:0], {9'h000, b[2:0], 12'h123});
      `CHK(overlay_hit_q, 1'h1);
      `CHK(mapped_addr_q, 24'hFF_DD23);
      `CHK(flash_protect_q, 1'h1);
      `CHK(prog_allowed_q, 1'h0);
      // Top of the block must land at the top of the overlay window
      remap(1'h1, b[2:0], {9'h000, b[2:0], 12'hFFF});
      `CHK(overlay_hit_q, 1'h1);
      `CHK(mapped_addr_q, 24'hFF_EBFF);
      remap(1'h1, b[2:0], {9'h000, b[2:0] + 3'h1, 12'h123});
      `CHK(overlay_hit_q, 1'h0);
      remap(1'h0, b[2:0], {9'h000, b[2:0], 12'hFFF});
      `CHK(overlay_hit_q, 1'h0);
      `CHK(flash_protect_q, 1'h0);
      `CHK(prog_allowed_q, 1'h1);
    end
    // RAM stalls for two bytes; the write port register holds the first, the buffer the second
    @(posedge mclk);
    ram_wr_ready <= 1'h0;
    fle_host_inst.send(dat[0]);
    fle_host_inst.send(dat[1]);
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    `CHK(ram_wr_valid_q, 1'h1);
    `CHK(ram_wr_q.addr, 24'hFF_EC00);
    `CHK(ram_wr_q.data, dat[0]);
    `CHK(branch_cnt, 0);
    @(posedge mclk);
    ram_wr_ready <= 1'h1;
    fle_host_inst.send(dat[2]);
    // Stop bit is sampled mid-bit, so the writes drain before the frame ends
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    `CHK(branch_cnt, 1);
    `CHK(branch_addr_q, 24'hFF_EC00);
    `CHK(rx_overrun_q, 1'h0);
    `CHK(got.size(), 3);
    for (int i = 0; i < 3; i++) begin
      `CHK(got[i].addr, 24'hFF_EC00 + 24'(i));
      `CHK(got[i].data, dat[i]);
    end
    stop_test();
  end
endmodule
bind fle_ctrl fle_chk fle_chk_inst (.mclk(mclk), .reset_n(reset_n),
  .emulation_select(emulation_select), .area_select_bit2(area_select_bit2),
  .area_select_bit1(area_select_bit1), .area_select_bit0(area_select_bit0),
  .flash_write_enable_pin(flash_write_enable_pin), .cpu_addr(cpu_addr),
  .ram_wr_ready(ram_wr_ready), .mapped_addr_q(mapped_addr_q), .overlay_hit_q(overlay_hit_q),
  .flash_protect_q(flash_protect_q), .prog_allowed_q(prog_allowed_q),
  .boot_mode_q(boot_mode_q), .user_prog_mode_q(user_prog_mode_q),
  .ram_wr_valid_q(ram_wr_valid_q), .ram_wr_q(ram_wr_q), .branch_q(branch_q),
  .branch_addr_q(branch_addr_q));
`default_nettype wire

// [verif/fle_host.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Host sending the programming program
// ----------------------------------------
module fle_host #(
  parameter int BIT_CYCLES = 880 // Clock cycles per serial bit
) (
  input wire logic mclk,
  output logic rxd
);
  // Line idles high, so a start bit is never faked
  initial rxd = 1'h1;
  // One 8N1 frame, LSB first; stop bit leaves the line idle
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      rxd <= frame[i];
      repeat (BIT_CYCLES - 1) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire
